// file: lieim_core.sv
// Link interrupt event latch and low isochronous receive channel mask
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "lieim_params.svh"

module lieim_core #(
    parameter int OVERRUN_CYCLES = `LIEIM_OVERRUN_CYC
) (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_b_i,
    // Register port
    input  wire lieim_pkg::lieim_req_t req_i,
    output logic [31:0]               rdata_o,
    // Controls owned by neighbouring registers
    input  wire logic [31:0]          irq_mask_i,
    input  wire logic                 late_ack_enable_i,
    input  wire logic                 cycle_root_enable_i,
    output logic                      cycle_root_clear_o,
    // Late acknowledge conditions
    input  wire logic                 rx_fifo_pending_i,
    input  wire logic                 phys_resp_busy_i,
    input  wire logic                 late_ack_sent_i,
    // PHY and link sources
    input  wire logic                 phy_byte_received_i,
    input  wire logic                 phy_status_irq_i,
    input  wire logic                 access_clock_missing_i,
    input  wire logic                 bus_reinit_entered_i,
    input  wire logic                 id_stream_done_i,
    input  wire logic                 atomic_reply_fault_i,
    input  wire logic                 buffered_write_fault_i,
    // Cycle timing sources
    input  wire logic                 cycle_start_sent_i,
    input  wire logic                 subaction_gap_i,
    input  wire logic                 arb_reset_gap_i,
    input  wire logic                 rx_cycle_start_i,
    input  wire lieim_pkg::lieim_cyc_t rx_cycle_i,
    input  wire lieim_pkg::lieim_cyc_t timer_i,
    // Fault source and the async contexts it names
    input  wire logic                 fatal_fault_i,
    input  wire lieim_pkg::lieim_async_t fatal_ctx_i,
    // DMA context sources
    input  wire lieim_pkg::lieim_async_t async_i,
    input  wire logic [31:0]          iso_rx_event_i,
    input  wire logic [31:0]          iso_rx_mask_i,
    input  wire logic [31:0]          iso_tx_event_i,
    input  wire logic [31:0]          iso_tx_mask_i,
    // Results
    output logic [31:0]               rx_channel_enable_o,
    output logic [31:0]               event_raw_o,
    output logic                      irq_o
);

    localparam int OV_W = $clog2(OVERRUN_CYCLES + 1);

    // =========================================================================
    // Parameter check
    // =========================================================================
    if (OVERRUN_CYCLES < 2) begin : g_bad_overrun
        $error("OVERRUN_CYCLES must be at least 2");
    end

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic rising(input logic now, input logic was);
        rising = now & ~was;
    endfunction

    function automatic logic hit(input logic [11:0] addr,
                                 input logic [11:0] ofs);
        hit = (addr == ofs);
    endfunction

    // =========================================================================
    // Declarations
    // =========================================================================
    logic [31:0]                 chan_q;
    logic [31:0]                 chan_d;
    logic [31:0]                 evt_q;
    logic [31:0]                 evt_d;
    logic [31:0]                 rdata_q;
    logic [31:0]                 rdata_d;
    logic [31:0]                 src_lvl;
    logic [31:0]                 src_prev_q;
    logic [31:0]                 hw_set;
    logic [31:0]                 hw_clr;
    logic [31:0]                 sw_set;
    logic [31:0]                 sw_clr;
    logic [31:0]                 evt_view;
    logic [31:0]                 masked_evt;
    logic [5:0]                  blocked_q;
    logic [5:0]                  blocked_d;
    logic [5:0]                  async_vec;
    logic [5:0]                  fatal_vec;
    logic [5:0]                  async_gated;
    logic                        sec6_prev_q;
    logic                        cnt0_prev_q;
    logic                        seen_start_q;
    logic                        seen_start_d;
    logic                        sync_seen_q;
    logic                        sync_seen_d;
    logic                        new_period;
    logic                        sec6_toggle;
    logic                        mismatch;
    logic                        missed_late;
    logic                        missed_early;
    logic                        late_ack_cond;
    logic                        iso_rx_summary;
    logic                        iso_tx_summary;
    logic                        hit_chan_set;
    logic                        hit_chan_clr;
    logic                        hit_evt_set;
    logic                        hit_evt_clr;
    logic                        overrun;
    lieim_pkg::lieim_ov_state_t  ov_state_q;
    lieim_pkg::lieim_ov_state_t  ov_state_d;
    logic [OV_W-1:0]             ov_cnt_q;
    logic [OV_W-1:0]             ov_cnt_d;

    // =========================================================================
    // Address decode
    // =========================================================================
    assign hit_chan_set = hit(req_i.addr, `LIEIM_OFS_CHAN_SET);
    assign hit_chan_clr = hit(req_i.addr, `LIEIM_OFS_CHAN_CLR);
    assign hit_evt_set  = hit(req_i.addr, `LIEIM_OFS_EVT_SET);
    assign hit_evt_clr  = hit(req_i.addr, `LIEIM_OFS_EVT_CLR);

    // =========================================================================
    // Channel enable mask
    // =========================================================================
    // Only 1 bits act; a write of 0s leaves the mask alone
    assign chan_d = req_i.wr & hit_chan_set ? chan_q | req_i.wdata
                  : req_i.wr & hit_chan_clr ? chan_q & ~req_i.wdata
                  : chan_q;

    // =========================================================================
    // Cycle timing decode
    // =========================================================================
    assign new_period  = timer_i.count[0] ^ cnt0_prev_q;
    assign sec6_toggle = timer_i.seconds[`LIEIM_SEC_TOGGLE_BIT]
                         ^ sec6_prev_q;
    assign mismatch    = rx_cycle_start_i & (rx_cycle_i != timer_i);

    // A start seen between two syncs closes the window for both checks
    assign seen_start_d = new_period ? 1'b0
                        : seen_start_q | cycle_start_sent_i | rx_cycle_start_i;
    assign sync_seen_d  = new_period | sync_seen_q;
    assign missed_late  = new_period & sync_seen_q & ~seen_start_q;
    // Prediction: a gap arrives after the sync with no start in between
    assign missed_early = ~new_period & sync_seen_q & ~seen_start_q
                          & ~cycle_start_sent_i & ~rx_cycle_start_i
                          & (subaction_gap_i | arb_reset_gap_i);

    // =========================================================================
    // Cycle overrun timer
    // =========================================================================
    // Counts from the start of a sent cycle start to the next subaction gap
    always_comb
    begin
        ov_state_d = ov_state_q;
        ov_cnt_d   = ov_cnt_q;
        overrun    = 1'b0;
        case (ov_state_q)
            lieim_pkg::LIEIM_OV_IDLE:
            begin
                ov_cnt_d = '0;
                if (cycle_root_enable_i && cycle_start_sent_i)
                begin
                    ov_state_d = lieim_pkg::LIEIM_OV_TIMING;
                end
            end
            lieim_pkg::LIEIM_OV_TIMING:
            begin
                if (!cycle_root_enable_i || subaction_gap_i)
                begin
                    ov_state_d = lieim_pkg::LIEIM_OV_IDLE;
                end
                else if (ov_cnt_q == OV_W'(OVERRUN_CYCLES))
                begin
                    overrun    = 1'b1;
                    ov_state_d = lieim_pkg::LIEIM_OV_TRIPPED;
                end
                else
                begin
                    ov_cnt_d = ov_cnt_q + 1'b1;
                end
            end
            lieim_pkg::LIEIM_OV_TRIPPED:
            begin
                // Wait for the clear to land before arming again
                if (!cycle_root_enable_i)
                begin
                    ov_state_d = lieim_pkg::LIEIM_OV_IDLE;
                end
            end
            default:
            begin
                ov_state_d = lieim_pkg::LIEIM_OV_IDLE;
            end
        endcase
    end

    // =========================================================================
    // Event sources
    // =========================================================================
    assign late_ack_cond = late_ack_enable_i
                           & (rx_fifo_pending_i | phys_resp_busy_i
                              | late_ack_sent_i);

    assign async_vec = async_i;
    assign fatal_vec = fatal_ctx_i;
    // Contexts that caused a fault stay quiet until the fault is cleared
    assign async_gated = async_vec
                         & ~(blocked_q & {6{evt_q[`LIEIM_BIT_FATAL]}});
    assign blocked_d   = evt_q[`LIEIM_BIT_FATAL] | fatal_fault_i
                         ? blocked_q | (fatal_vec & {6{fatal_fault_i}})
                         : 6'h00;

    // Levels whose rising edge latches an event
    always_comb
    begin
        src_lvl                          = '0;
        src_lvl[`LIEIM_BIT_LATE_ACK]     = late_ack_cond;
        src_lvl[`LIEIM_BIT_PHY_BYTE]     = phy_byte_received_i;
        src_lvl[`LIEIM_BIT_FATAL]        = fatal_fault_i;
        src_lvl[`LIEIM_BIT_PHY_IRQ]      = phy_status_irq_i;
        src_lvl[`LIEIM_BIT_CLK_MISSING]  = access_clock_missing_i;
        src_lvl[`LIEIM_BIT_BUS_REINIT]   = bus_reinit_entered_i;
        src_lvl[`LIEIM_BIT_ID_DONE]      = id_stream_done_i;
        src_lvl[`LIEIM_BIT_ATOMIC]       = atomic_reply_fault_i;
        src_lvl[`LIEIM_BIT_BUF_WRITE]    = buffered_write_fault_i;
        src_lvl[5:0]                     = async_gated;
    end

    always_comb
    begin
        hw_set = '0;
        for (int i = 0; i < 32; i++)
        begin
            hw_set[i] = rising(src_lvl[i], src_prev_q[i]);
        end
        hw_set[`LIEIM_BIT_OVERRUN]    = overrun;
        hw_set[`LIEIM_BIT_MISMATCH]   = mismatch;
        hw_set[`LIEIM_BIT_MISSED]     = missed_late | missed_early;
        hw_set[`LIEIM_BIT_SEC6]       = sec6_toggle;
        hw_set[`LIEIM_BIT_NEW_PERIOD] = new_period;
        hw_set[`LIEIM_BIT_ID_STICKY]  = hw_set[`LIEIM_BIT_ID_DONE];
        hw_set[`LIEIM_BIT_SOFT]       = 1'b0;
    end

    // Bus reset knocks out the completion flag only, never its sticky twin
    assign hw_clr = {{(31-`LIEIM_BIT_ID_DONE){1'b0}},
                     hw_set[`LIEIM_BIT_BUS_REINIT],
                     {`LIEIM_BIT_ID_DONE{1'b0}}};

    // =========================================================================
    // Event latch
    // =========================================================================
    assign sw_set = {32{req_i.wr & hit_evt_set}} & req_i.wdata;
    assign sw_clr = {32{req_i.wr & hit_evt_clr}} & req_i.wdata;

    // Hardware sets win over any clear arriving in the same cycle
    assign evt_d = ((evt_q & ~sw_clr & ~hw_clr) | sw_set | hw_set)
                   & `LIEIM_LATCH_MASK;

    // =========================================================================
    // Live summaries and read view
    // =========================================================================
    assign iso_rx_summary = |(iso_rx_event_i & iso_rx_mask_i);
    assign iso_tx_summary = |(iso_tx_event_i & iso_tx_mask_i);

    always_comb
    begin
        evt_view                    = evt_q & `LIEIM_LATCH_MASK;
        evt_view[`LIEIM_BIT_ISO_RX] = iso_rx_summary;
        evt_view[`LIEIM_BIT_ISO_TX] = iso_tx_summary;
    end

    assign masked_evt = evt_view & irq_mask_i;

    // Unmapped offsets read as zero; reads have no side effect
    assign rdata_d = !req_i.rd                 ? `LIEIM_READ_IDLE
                   : hit_chan_set | hit_chan_clr ? chan_q
                   : hit_evt_set | hit_evt_clr   ? masked_evt
                   : `LIEIM_READ_IDLE;

    // =========================================================================
    // Registers
    // =========================================================================
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            chan_q       <= `LIEIM_CHAN_RESET;
            evt_q        <= `LIEIM_EVT_RESET;
            rdata_q      <= `LIEIM_READ_IDLE;
            src_prev_q   <= '0;
            blocked_q    <= '0;
            ov_state_q   <= lieim_pkg::LIEIM_OV_IDLE;
            ov_cnt_q     <= '0;
        end
        else
        begin
            chan_q       <= chan_d;
            evt_q        <= evt_d;
            rdata_q      <= rdata_d;
            src_prev_q   <= src_lvl;
            blocked_q    <= blocked_d;
            ov_state_q   <= ov_state_d;
            ov_cnt_q     <= ov_cnt_d;
        end
    end

    // Timer history resets to 0; a first sample with the bit at 1 counts as a toggle
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sec6_prev_q  <= 1'b0;
            cnt0_prev_q  <= 1'b0;
            seen_start_q <= 1'b0;
            sync_seen_q  <= 1'b0;
        end
        else
        begin
            sec6_prev_q  <= timer_i.seconds[`LIEIM_SEC_TOGGLE_BIT];
            cnt0_prev_q  <= timer_i.count[0];
            seen_start_q <= seen_start_d;
            sync_seen_q  <= sync_seen_d;
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    assign rdata_o             = rdata_q;
    assign rx_channel_enable_o = chan_q;
    assign event_raw_o         = evt_view;
    assign cycle_root_clear_o  = overrun;
    assign irq_o = irq_mask_i[`LIEIM_BIT_GLOBAL_EN]
                   & |(masked_evt & ~(32'h1 << `LIEIM_BIT_GLOBAL_EN));

endmodule

// file: lieim_core_assertions.sv
// Port-level assertions for the link event latch
`timescale 1ns/100ps
module lieim_core_checker #(
    parameter int OVERRUN_CYCLES = 20
) (
    input wire logic                  mclk_i,
    input wire logic                  rst_b_i,
    input wire lieim_pkg::lieim_req_t req_i,
    input wire logic [31:0]           rdata_o,
    input wire logic [31:0]           irq_mask_i,
    input wire logic                  bus_reinit_entered_i,
    input wire logic                  id_stream_done_i,
    input wire logic [31:0]           iso_rx_event_i,
    input wire logic [31:0]           iso_rx_mask_i,
    input wire logic [31:0]           iso_tx_event_i,
    input wire logic [31:0]           iso_tx_mask_i,
    input wire logic [31:0]           rx_channel_enable_o,
    input wire logic [31:0]           event_raw_o,
    input wire logic                  irq_o
);
    // ========================================
    // Decode and defaults
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire chan_wr = req_i.wr && (req_i.addr == 12'h078 ||
                                req_i.addr == 12'h07C);
    wire ev_clr  = req_i.wr && req_i.addr == 12'h084;
    // ========================================
    // Properties
    property p_read_masked;
        req_i.rd && req_i.addr == 12'h080 |=>
            rdata_o == ($past(event_raw_o) & $past(irq_mask_i));
    endproperty
    a_read_masked: assert property (p_read_masked)
        else $error("event read is not events and mask");
    property p_reserved;
        (event_raw_o & 32'hD000_7C00) == '0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved event bit is set");
    property p_irq;
        irq_o == (irq_mask_i[31] && |(event_raw_o & irq_mask_i & 32'h7FFF_FFFF));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output wrong");
    property p_chan_set;
        req_i.wr && req_i.addr == 12'h078 |=> rx_channel_enable_o ==
            ($past(rx_channel_enable_o) | $past(req_i.wdata));
    endproperty
    a_chan_set: assert property (p_chan_set)
        else $error("channel set wrong");
    property p_chan_hold;
        !chan_wr |=> $stable(rx_channel_enable_o);
    endproperty
    a_chan_hold: assert property (p_chan_hold)
        else $error("channel mask moved without a write");
    property p_clr_only;
        |($past(event_raw_o) & ~event_raw_o & 32'h2FFE_833F) |-> $past(ev_clr);
    endproperty
    a_clr_only: assert property (p_clr_only)
        else $error("event cleared without a clear write");
    property p_reinit;
        $rose(bus_reinit_entered_i) && !$rose(id_stream_done_i) && !req_i.wr
            |=> event_raw_o[17] && !event_raw_o[16] && $stable(event_raw_o[15]);
    endproperty
    a_reinit: assert property (p_reinit)
        else $error("bus reinit event bits wrong");
    property p_iso_live;
        event_raw_o[7:6] == {|(iso_rx_event_i & iso_rx_mask_i),
                             |(iso_tx_event_i & iso_tx_mask_i)};
    endproperty
    a_iso_live: assert property (p_iso_live)
        else $error("iso summary bits wrong");
    c_irq: cover property ($rose(irq_o));
    c_clear: cover property (ev_clr);
    c_reinit: cover property ($rose(bus_reinit_entered_i));
endmodule

// file: lieim_params.svh
// Offsets, field positions, reset values and timing counts of the event latch
// Functional notes
// - 32-bit channel enable mask; 1s set at 78h, 1s clear at 7Ch
// - Event bit sets on source rising edge or software 1 at 80h
// - Event bit clears only by software 1 at 84h, or bit 16 on bus reset; reads never clear
// - Event read returns latched events ANDed with interrupt mask bits
// - Bits 31, 30, 28 and 14 to 10 always read zero
// - Bit 29 is a software event, set and cleared only by software
// - Bit 27 sets when late-ack enable and FIFO, busy or tardy ack
// - Bit 26 sets when a PHY register byte is received
// - Root enabled and cycle over 125 us: set bit 25, clear root enable
// - Bit 24 on subunit halt; blocks offending contexts' events while set
// - Bit 23 sets when received cycle start differs from local timer
// - Bit 22 on missing cycle start between syncs, or early prediction
// - Bit 21 sets when seconds counter bit 6 changes
// - Bit 20 sets when cycle count low bit toggles
// - Bit 19 sets on PHY interrupt request via status transfer
// - Bit 18 sets on register access failing for missing link clock
// - Bit 17 sets on bus reset, clearing bit 16; 16 sets on ID done
// - Bit 15 sets with bit 16 and ignores bus reset
// - Bit 9 sets when lock response misses ack_complete
// - Bit 8 sets on host bus error writing acknowledged write
// - Bits 7 and 6 are live OR of masked per-context iso events
// - Bits 5, 4 on async receive packets; 3 to 0 on DMA completion
// - Interrupt output needs global enable and a masked event
`ifndef LIEIM_PARAMS_SVH
`define LIEIM_PARAMS_SVH

`define LIEIM_ADDR_W          12
`define LIEIM_OFS_CHAN_SET    12'h078
`define LIEIM_OFS_CHAN_CLR    12'h07C
`define LIEIM_OFS_EVT_SET     12'h080
`define LIEIM_OFS_EVT_CLR     12'h084

`define LIEIM_CHAN_RESET      32'h0000_0000
`define LIEIM_EVT_RESET       32'h0000_0000
`define LIEIM_READ_IDLE       32'h0000_0000
// Bits that hold latched state; reserved and live bits are excluded
`define LIEIM_LATCH_MASK      32'h2FFF_833F

`define LIEIM_BIT_GLOBAL_EN   31
`define LIEIM_BIT_SOFT        29
`define LIEIM_BIT_LATE_ACK    27
`define LIEIM_BIT_PHY_BYTE    26
`define LIEIM_BIT_OVERRUN     25
`define LIEIM_BIT_FATAL       24
`define LIEIM_BIT_MISMATCH    23
`define LIEIM_BIT_MISSED      22
`define LIEIM_BIT_SEC6        21
`define LIEIM_BIT_NEW_PERIOD  20
`define LIEIM_BIT_PHY_IRQ     19
`define LIEIM_BIT_CLK_MISSING 18
`define LIEIM_BIT_BUS_REINIT  17
`define LIEIM_BIT_ID_DONE     16
`define LIEIM_BIT_ID_STICKY   15
`define LIEIM_BIT_ATOMIC      9
`define LIEIM_BIT_BUF_WRITE   8
`define LIEIM_BIT_ISO_RX      7
`define LIEIM_BIT_ISO_TX      6
`define LIEIM_SEC_TOGGLE_BIT  6

`define LIEIM_CLK_MHZ         200
`define LIEIM_OVERRUN_US      125
`define LIEIM_OVERRUN_CYC     (`LIEIM_OVERRUN_US * `LIEIM_CLK_MHZ)

`endif

// file: lieim_pkg.sv
// Types shared by the link event latch and its users
package lieim_pkg;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } lieim_req_t;

    typedef struct packed {
        logic [6:0]  seconds;
        logic [12:0] count;
    } lieim_cyc_t;

    typedef struct packed {
        logic reply_packet_in;
        logic request_packet_in;
        logic reply_rx_done;
        logic request_rx_done;
        logic reply_tx_done;
        logic request_tx_done;
    } lieim_async_t;

    typedef enum logic [1:0] {
        LIEIM_OV_IDLE,
        LIEIM_OV_TIMING,
        LIEIM_OV_TRIPPED
    } lieim_ov_state_t;

endpackage

// file: test_link_interrupt_event_and_iso_mask.sv
// Self-checking bench for the link event latch
`timescale 1ns/100ps
module test_link_interrupt_event_and_iso_mask;
    logic                  mclk = 1'b0;
    logic                  rst_b = 1'b0;
    lieim_pkg::lieim_req_t req = '0;
    lieim_pkg::lieim_cyc_t tmr = '0, rxc = '0;
    lieim_pkg::lieim_async_t fctx = '0;
    logic [31:0]           rdata, chan, raw, mask = '0;
    logic [31:0]           ire = '0, irm = '0, ite = '0, itm = '0;
    logic [20:0]           src = '0;
    logic                  lae = 1'b0, cre = 1'b0, root_clr, irq;
    int                    errors = 0, tests_run = 0;
    // Event bit raised by each single-source pulse
    int evb [15] = '{26, 19, 18, 9, 8, 0, 1, 2, 3, 4, 5, 27, 27, 27, 24};
    always #2.5 mclk = ~mclk;
    lieim_core #(.OVERRUN_CYCLES(20)) dut_u (
        .mclk_i(mclk), .rst_b_i(rst_b), .req_i(req), .rdata_o(rdata),
        .irq_mask_i(mask), .late_ack_enable_i(lae),
        .cycle_root_enable_i(cre), .cycle_root_clear_o(root_clr),
        .rx_fifo_pending_i(src[12]), .phys_resp_busy_i(src[13]),
        .late_ack_sent_i(src[11]), .phy_byte_received_i(src[0]),
        .phy_status_irq_i(src[1]), .access_clock_missing_i(src[2]),
        .bus_reinit_entered_i(src[16]), .id_stream_done_i(src[15]),
        .atomic_reply_fault_i(src[3]), .buffered_write_fault_i(src[4]),
        .cycle_start_sent_i(src[18]), .subaction_gap_i(src[19]),
        .arb_reset_gap_i(src[20]), .rx_cycle_start_i(src[17]),
        .rx_cycle_i(rxc), .timer_i(tmr), .fatal_fault_i(src[14]),
        .fatal_ctx_i(fctx), .async_i(lieim_pkg::lieim_async_t'(src[10:5])),
        .iso_rx_event_i(ire), .iso_rx_mask_i(irm), .iso_tx_event_i(ite),
        .iso_tx_mask_i(itm), .rx_channel_enable_o(chan),
        .event_raw_o(raw), .irq_o(irq));
    // ========================================
    // Bus and compare helpers
    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, string nm);
        @(posedge mclk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        @(posedge mclk);
        chk(nm, e, rdata);
    endtask
    // Ends on the edge where the latched result is first visible
    task automatic pulse(input int k);
        @(posedge mclk);
        src <= 21'h1 << k;
        @(posedge mclk);
        src <= '0;
        @(posedge mclk);
    endtask
    task automatic test_done;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic s_chan;
        wr(12'h078, 32'h8000_0001);
        wr(12'h078, 32'h0000_0F00);
        wr(12'h07C, 32'h8000_0100);
        wr(12'h088, 32'hFFFF_FFFF);
        @(posedge mclk);
        chk("channel mask", 32'h0000_0E01, chan);
        rd(12'h090, '0, "unmapped read");
    endtask
    task automatic s_soft;
        mask <= 32'hFFFF_FFFF;
        wr(12'h080, 32'h2000_0000);
        @(posedge mclk);
        chk("irq on", 32'h1, {31'h0, irq});
        rd(12'h080, 32'h2000_0000, "soft read");
        rd(12'h084, 32'h2000_0000, "second read");
        mask <= 32'h7FFF_FFFF;
        @(posedge mclk);
        chk("global off", '0, {31'h0, irq});
        mask <= 32'hDFFF_FFFF;
        rd(12'h080, '0, "masked read");
        wr(12'h084, 32'h2000_0000);
        @(posedge mclk);
        chk("soft clear", '0, raw);
    endtask
    task automatic s_all;
        wr(12'h080, 32'hFFFF_FFFF);
        wr(12'h084, '0);
        @(posedge mclk);
        chk("set all", ~32'hD000_7CC0, raw);
        wr(12'h084, 32'hFFFF_FFFF);
        @(posedge mclk);
        chk("clear all", '0, raw);
    endtask
    task automatic s_src;
        lae <= 1'b1;
        for (int k = 0; k < 15; k++)
        begin
            pulse(k);
            chk("source", 32'h1 << evb[k], raw);
            wr(12'h084, 32'hFFFF_FFFF);
        end
        lae <= 1'b0;
        pulse(11);
        chk("late ack off", '0, raw);
        fctx <= lieim_pkg::lieim_async_t'(6'h20);
        pulse(14);
        pulse(10);
        chk("blocked", 32'h0100_0000, raw);
        wr(12'h084, 32'h0100_0000);
        pulse(10);
        chk("unblocked", 32'h0000_0020, raw);
        pulse(15);
        chk("id done", 32'h0001_8020, raw);
        pulse(16);
        chk("bus reinit", 32'h0002_8020, raw);
        wr(12'h084, 32'hFFFF_FFFF);
    endtask
    task automatic s_timing;
        int n;
        @(posedge mclk);
        tmr <= lieim_pkg::lieim_cyc_t'(20'h0_0001);
        @(posedge mclk);
        tmr <= lieim_pkg::lieim_cyc_t'(20'h8_0001);
        @(posedge mclk);
        tmr <= lieim_pkg::lieim_cyc_t'(20'h8_0000);
        pulse(17);
        chk("cycle events", 32'h00F0_0000, raw);
        wr(12'h084, 32'hFFFF_FFFF);
        cre <= 1'b1;
        pulse(18);
        for (n = 0; n < 40 && root_clr !== 1'b1; n++)
            @(posedge mclk);
        chk("root clear", 32'h1, {31'h0, root_clr});
        chk("overrun delay", 32'h0000_0014, n);
        @(posedge mclk);
        chk("overrun", 32'h0200_0000, raw);
        cre <= 1'b0;
        ire <= 32'h0001_0000;
        irm <= 32'h0001_0000;
        ite <= 32'h0000_0004;
        @(posedge mclk);
        chk("iso live", 32'h0200_0080, raw);
        // Sync then an arbitration gap with no start predicts a lost cycle
        wr(12'h084, 32'hFFFF_FFFF);
        tmr <= lieim_pkg::lieim_cyc_t'(20'h8_0001);
        rxc <= lieim_pkg::lieim_cyc_t'(20'h8_0001);
        pulse(20);
        chk("early miss", 32'h0050_0080, raw);
        wr(12'h084, 32'hFFFF_FFFF);
        cre <= 1'b1;
        pulse(18);
        pulse(19);
        pulse(17);
        repeat (25) @(posedge mclk);
        chk("gap in time", 32'h0000_0080, raw);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        chk("chan reset", '0, chan);
        s_chan();
        s_soft();
        s_all();
        s_src();
        s_timing();
        test_done();
    end
    initial
    begin
        repeat (3000) @(posedge mclk);
        errors++;
        test_done();
    end
endmodule
bind lieim_core lieim_core_checker #(.OVERRUN_CYCLES(OVERRUN_CYCLES)) chk_u (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req_i), .rdata_o(rdata_o),
    .irq_mask_i(irq_mask_i), .bus_reinit_entered_i(bus_reinit_entered_i),
    .id_stream_done_i(id_stream_done_i), .iso_rx_event_i(iso_rx_event_i),
    .iso_rx_mask_i(iso_rx_mask_i), .iso_tx_event_i(iso_tx_event_i),
    .iso_tx_mask_i(iso_tx_mask_i), .rx_channel_enable_o(rx_channel_enable_o),
    .event_raw_o(event_raw_o), .irq_o(irq_o));
